/* hdl/gpio_cmd_pkg.sv */
// Purpose: Shared constants for the pin command interpreter
// Assumes: 32-bit word-aligned register map, byte-wide link
// Notes:   Masks are always 32 bits wide on the link
package gpio_cmd_pkg;

   localparam int MASK_W   = 32;
   localparam int NPINS    = 11;
   localparam int FRAME_LEN = 9;
   localparam int RESP_LEN  = 5;

   // Command codes
   localparam logic [7:0] CMD_GET_FUNC  = 8'h10;
   localparam logic [7:0] CMD_GET_DIR   = 8'h11;
   localparam logic [7:0] CMD_GET_ALOW  = 8'h12;
   localparam logic [7:0] CMD_GET_STATE = 8'h13;
   localparam logic [7:0] CMD_SET_DIR   = 8'h19;
   localparam logic [7:0] CMD_SET_ALOW  = 8'h1a;
   localparam logic [7:0] CMD_SET_STATE = 8'h1b;
   localparam logic [7:0] ERR_BYTE      = 8'hff;

   // Frame byte positions
   localparam logic [3:0] POS_CMD     = 4'h0;
   localparam logic [3:0] POS_P1_LAST = 4'h4;
   localparam logic [3:0] POS_LAST    = 4'h8;

   // Response lengths in bytes
   localparam logic [2:0] LEN_OK  = 3'h5;
   localparam logic [2:0] LEN_ERR = 3'h1;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_FUNC   = 8'h08;
   localparam logic [7:0] OFS_DIR    = 8'h0c;
   localparam logic [7:0] OFS_ALOW   = 8'h10;
   localparam logic [7:0] OFS_STATE  = 8'h14;
   localparam logic [7:0] OFS_COUNT  = 8'h18;

   // Field positions
   localparam int CTRL_OFF_BIT   = 0;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_CNT_LSB   = 4;

   // Values after reset
   localparam logic       RST_SERVICE_OFF = 1'b0;
   localparam logic [31:0] DEF_FUNC = 32'hffff_ffff;
   localparam logic [31:0] DEF_DIR  = 32'h0000_0000;
   localparam logic [31:0] DEF_ALOW = 32'hffff_ffff;
   localparam logic [31:0] DEF_LVL  = 32'h0000_0000;

   // AHB encodings
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic       HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      PH_COLLECT,
      PH_EXECUTE,
      PH_RESPOND
   } phase_t;

endpackage

/* hdl/gpio_command_interpreter.sv */
// Purpose: Pin command interpreter for nine-byte remote frames
// Assumes: Byte streams and boot inputs on the clock's own domain
// Notes:   Pin inputs are synchronised; registers over AHB-Lite
`timescale 1ns/100ps
`default_nettype none
module gpio_command_interpreter #(
   parameter int NPINS = gpio_cmd_pkg::NPINS
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // Boot pin configuration, sampled during reset
   input  wire logic              boot_valid,
   input  wire logic [NPINS-1:0]  boot_func,
   input  wire logic [NPINS-1:0]  boot_dir,
   input  wire logic [NPINS-1:0]  boot_alow,
   // Command bytes in
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   output logic                   rx_ready,
   // Response bytes out
   output logic                   tx_valid,
   output logic [7:0]             tx_data,
   input  wire logic              tx_ready,
   // Pins
   input  wire logic [NPINS-1:0]  pin_in,
   output logic [NPINS-1:0]       pin_out,
   output logic [NPINS-1:0]       pin_oe,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp
);

   generate
      if (NPINS < 1 || NPINS > gpio_cmd_pkg::MASK_W) begin : g_chk
         $error("NPINS must lie between 1 and 32");
      end
   endgenerate

   typedef struct packed {
      gpio_cmd_pkg::phase_t phase;
      logic [3:0]       count;
      logic [7:0]       cmd;
      logic [31:0]      p1;
      logic [31:0]      p2;
      logic [NPINS-1:0] func;
      logic [NPINS-1:0] dir;
      logic [NPINS-1:0] alow;
      logic [NPINS-1:0] lvl;
      logic [NPINS-1:0] sync1;
      logic [NPINS-1:0] sync2;
      logic [NPINS-1:0] drv;
      logic [NPINS-1:0] oe;
      logic             start;
      logic             short_err;
      logic [7:0]       rcode;
      logic [31:0]      rparam;
      logic             ahb_wr;
      logic [7:0]       ahb_addr;
      logic [31:0]      rdata;
      logic             service_off;
      logic [15:0]      cmd_count;
      logic [15:0]      err_count;
   } core_t;

   core_t q;
   core_t next_q;

   resp_if resp ();

   ////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] widen(input logic [NPINS-1:0] v);
      logic [31:0] w;
      w = '0;
      w[NPINS-1:0] = v;
      return w;
   endfunction

   function automatic logic cmd_valid(input logic [7:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         gpio_cmd_pkg::CMD_GET_FUNC,
         gpio_cmd_pkg::CMD_GET_DIR,
         gpio_cmd_pkg::CMD_GET_ALOW,
         gpio_cmd_pkg::CMD_GET_STATE,
         gpio_cmd_pkg::CMD_SET_DIR,
         gpio_cmd_pkg::CMD_SET_ALOW,
         gpio_cmd_pkg::CMD_SET_STATE: ok = 1'b1;
         default:                     ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Register window is the lowest 256 bytes
   function automatic logic mapped(input logic [31:0] a);
      return (a[31:8] == 24'h000000);
   endfunction

   // Merge masked new values, only on GPIO pins
   function automatic logic [NPINS-1:0] merge(
      input logic [NPINS-1:0] old,
      input logic [NPINS-1:0] mask,
      input logic [NPINS-1:0] val
   );
      return (old & ~mask) | (val & mask);
   endfunction

   // Active state: output holds its level, input follows the pin
   function automatic logic [NPINS-1:0] active(
      input logic [NPINS-1:0] d,
      input logic [NPINS-1:0] l,
      input logic [NPINS-1:0] s,
      input logic [NPINS-1:0] a
   );
      return (d & l) | (~d & (s ^ a));
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Next-state logic

   logic [NPINS-1:0] gmask;
   logic [NPINS-1:0] gval;
   logic [NPINS-1:0] cur;
   logic             addr_phase;

   always_comb begin
      next_q     = q;
      gmask      = q.p1[NPINS-1:0] & q.func;
      gval       = q.p2[NPINS-1:0];
      cur        = '0;
      addr_phase = hsel && htrans[1] && hready;

      // Pin input synchroniser
      next_q.sync1 = pin_in;
      next_q.sync2 = q.sync1;
      next_q.start = 1'b0;

      unique case (q.phase)
         gpio_cmd_pkg::PH_COLLECT: begin
            if (q.service_off) begin
               next_q.count = '0;
            end else if (rx_valid) begin
               if (q.count == gpio_cmd_pkg::POS_CMD) begin
                  next_q.cmd = rx_data;
               end else if (q.count <= gpio_cmd_pkg::POS_P1_LAST) begin
                  next_q.p1 = {rx_data, q.p1[31:8]};
               end else begin
                  next_q.p2 = {rx_data, q.p2[31:8]};
               end
               if (q.count == gpio_cmd_pkg::POS_LAST) begin
                  next_q.count = '0;
                  next_q.phase = gpio_cmd_pkg::PH_EXECUTE;
               end else begin
                  next_q.count = q.count + 4'h1;
               end
            end
         end
         gpio_cmd_pkg::PH_EXECUTE: begin
            case (q.cmd)
               gpio_cmd_pkg::CMD_SET_DIR:
                  next_q.dir = merge(q.dir, gmask, gval);
               gpio_cmd_pkg::CMD_SET_ALOW:
                  next_q.alow = merge(q.alow, gmask, gval);
               gpio_cmd_pkg::CMD_SET_STATE:
                  next_q.lvl = merge(q.lvl, gmask, gval);
               default: ;
            endcase
            // Reply reflects updated values
            cur = active(next_q.dir, next_q.lvl, q.sync2, next_q.alow);
            next_q.rcode = q.cmd;
            case (q.cmd)
               gpio_cmd_pkg::CMD_GET_FUNC:
                  next_q.rparam = widen(q.func);
               gpio_cmd_pkg::CMD_GET_DIR,
               gpio_cmd_pkg::CMD_SET_DIR:
                  next_q.rparam = widen(next_q.dir & q.func);
               gpio_cmd_pkg::CMD_GET_ALOW,
               gpio_cmd_pkg::CMD_SET_ALOW:
                  next_q.rparam = widen(next_q.alow & q.func);
               gpio_cmd_pkg::CMD_GET_STATE,
               gpio_cmd_pkg::CMD_SET_STATE:
                  next_q.rparam = widen(cur & q.func);
               default: begin
                  next_q.rcode  = gpio_cmd_pkg::ERR_BYTE;
                  next_q.rparam = '0;
               end
            endcase
            next_q.short_err = !cmd_valid(q.cmd);
            if (cmd_valid(q.cmd)) begin
               next_q.cmd_count = q.cmd_count + 16'h1;
            end else begin
               next_q.err_count = q.err_count + 16'h1;
            end
            next_q.start = 1'b1;
            next_q.phase = gpio_cmd_pkg::PH_RESPOND;
         end
         gpio_cmd_pkg::PH_RESPOND: begin
            if (!resp.busy) begin
               next_q.phase = gpio_cmd_pkg::PH_COLLECT;
            end
         end
      endcase

      // Register bus: data phase of a write
      if (q.ahb_wr && q.ahb_addr == gpio_cmd_pkg::OFS_CTRL) begin
         next_q.service_off = hwdata[gpio_cmd_pkg::CTRL_OFF_BIT];
      end
      // Unmapped or subword writes never reach a register
      next_q.ahb_wr = addr_phase && hwrite && mapped(haddr)
                      && hsize == gpio_cmd_pkg::HSIZE_WORD;
      next_q.ahb_addr = {haddr[7:2], 2'b00};
      if (addr_phase && !hwrite) begin
         next_q.rdata = '0;
         if (mapped(haddr)) begin
            case ({haddr[7:2], 2'b00})
               gpio_cmd_pkg::OFS_CTRL:
                  next_q.rdata[gpio_cmd_pkg::CTRL_OFF_BIT] =
                     q.service_off;
               gpio_cmd_pkg::OFS_STATUS: begin
                  next_q.rdata[gpio_cmd_pkg::STAT_BUSY_BIT] =
                     (q.phase != gpio_cmd_pkg::PH_COLLECT);
                  next_q.rdata[gpio_cmd_pkg::STAT_CNT_LSB +: 4] =
                     q.count;
               end
               gpio_cmd_pkg::OFS_FUNC:
                  next_q.rdata = widen(q.func);
               gpio_cmd_pkg::OFS_DIR:
                  next_q.rdata = widen(q.dir);
               gpio_cmd_pkg::OFS_ALOW:
                  next_q.rdata = widen(q.alow);
               gpio_cmd_pkg::OFS_STATE:
                  next_q.rdata = widen(
                     active(q.dir, q.lvl, q.sync2, q.alow) & q.func);
               gpio_cmd_pkg::OFS_COUNT:
                  next_q.rdata = {q.err_count, q.cmd_count};
               default: next_q.rdata = '0;
            endcase
         end
      end else if (!q.ahb_wr && !addr_phase) begin
         next_q.rdata = q.rdata;
      end

      // Pin drive follows logical state and polarity
      next_q.drv = next_q.lvl ^ next_q.alow;
      next_q.oe  = next_q.dir & next_q.func;

      // Reset loads boot configuration if boot_valid, else defaults, never kept across it
      if (!nrst) begin
         next_q.phase       = gpio_cmd_pkg::PH_COLLECT;
         next_q.count       = '0;
         next_q.cmd         = '0;
         next_q.p1          = '0;
         next_q.p2          = '0;
         next_q.func = boot_valid ? boot_func
                       : gpio_cmd_pkg::DEF_FUNC[NPINS-1:0];
         next_q.dir  = boot_valid ? boot_dir
                       : gpio_cmd_pkg::DEF_DIR[NPINS-1:0];
         next_q.alow = boot_valid ? boot_alow
                       : gpio_cmd_pkg::DEF_ALOW[NPINS-1:0];
         next_q.lvl         = gpio_cmd_pkg::DEF_LVL[NPINS-1:0];
         next_q.sync1       = '0;
         next_q.sync2       = '0;
         next_q.drv         = '0;
         next_q.oe          = '0;
         next_q.start       = 1'b0;
         next_q.short_err   = 1'b0;
         next_q.rcode       = '0;
         next_q.rparam      = '0;
         next_q.ahb_wr      = 1'b0;
         next_q.ahb_addr    = '0;
         next_q.rdata       = '0;
         next_q.service_off = gpio_cmd_pkg::RST_SERVICE_OFF;
         next_q.cmd_count   = '0;
         next_q.err_count   = '0;
      end
   end

   always_ff @(posedge clock) begin
      q <= next_q;
   end

   ////////////////////////////////////////////////////////////////////
   // Response path

   assign resp.start     = q.start;
   assign resp.short_err = q.short_err;
   assign resp.code      = q.rcode;
   assign resp.param     = q.rparam;

   response_sender u_sender (
      .clock    (clock),
      .nrst     (nrst),
      .resp     (resp.sender),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_ready (tx_ready)
   );

   ////////////////////////////////////////////////////////////////////
   // Outputs

   // Disabled service swallows bytes without answering
   assign rx_ready  = nrst && (q.phase == gpio_cmd_pkg::PH_COLLECT);
   assign pin_out   = q.drv;
   assign pin_oe    = q.oe;
   assign hreadyout = 1'b1;
   assign hrdata    = q.rdata;
   assign hresp     = gpio_cmd_pkg::HRESP_OKAY;

endmodule
`default_nettype wire

/* hdl/resp_if.sv */
// Purpose: Response request from interpreter core to byte sender
// Assumes: Single clock, start is a one-cycle pulse
// Notes:   busy covers the start cycle as well
`timescale 1ns/100ps
`default_nettype none
interface resp_if;
   logic        start;
   logic        short_err;
   logic [7:0]  code;
   logic [31:0] param;
   logic        busy;

   modport core   (output start, short_err, code, param, input busy);
   modport sender (input start, short_err, code, param, output busy);
endinterface
`default_nettype wire

/* hdl/response_sender.sv */
// Purpose: Serialises a response, code first, parameter little-endian
// Assumes: Request arrives only while count is zero
// Notes:   Error response is the single byte held in code
`timescale 1ns/100ps
`default_nettype none
module response_sender (
   // Clock and reset
   input  wire logic   clock,
   input  wire logic   nrst,
   // Request from core
   resp_if.sender      resp,
   // Byte stream out
   output logic        tx_valid,
   output logic [7:0]  tx_data,
   input  wire logic   tx_ready
);

   typedef struct packed {
      logic [2:0]  count;
      logic [39:0] shift;
   } snd_t;

   snd_t q;
   snd_t next_q;

   always_comb begin
      next_q = q;
      if (!nrst) begin
         next_q.count = '0;
         next_q.shift = '0;
      end else if (resp.start) begin
         next_q.count = resp.short_err ? gpio_cmd_pkg::LEN_ERR
                                       : gpio_cmd_pkg::LEN_OK;
         next_q.shift = {resp.param, resp.code};
      end else if (tx_valid && tx_ready) begin
         next_q.count = q.count - 3'h1;
         next_q.shift = {8'h00, q.shift[39:8]};
      end
   end

   always_ff @(posedge clock) begin
      q <= next_q;
   end

   assign tx_valid  = (q.count != 3'h0);
   assign tx_data   = q.shift[7:0];
   assign resp.busy = (q.count != 3'h0) || resp.start;

endmodule
`default_nettype wire

/* tb/gpio_cmd_sva.sv */
// Purpose: Port checks on the response stream of the interpreter
// Assumes: One clock, nrst synchronous and active low
// Notes:   Tracks the byte position within a response only
`timescale 1ns/100ps
`default_nettype none
module gpio_cmd_sva (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // Byte streams
   input  wire logic       rx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   logic [2:0] pos;
   logic       take;

   assign take = tx_valid && tx_ready;

   always_ff @(posedge clock) begin
      if (!nrst || !tx_valid)
         pos <= 3'h0;
      else if (tx_ready)
         pos <= pos + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   no_overlap_a: assert property (
      !(rx_ready && tx_valid)) else $error("rx open during reply");
   tx_hold_a: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte dropped");
   err_single_a: assert property (
      take && pos == 3'h0 && tx_data == 8'hff |=> !tx_valid)
      else $error("error reply too long");
   resp_five_a: assert property (
      take && pos == 3'h4 |=> !tx_valid) else $error("reply too long");
   resp_run_a: assert property (
      take && pos < 3'h4 && !(pos == 3'h0 && tx_data == 8'hff)
      |=> tx_valid) else $error("reply too short");
   exec_gap_a: assert property (
      $fell(rx_ready) |=> !rx_ready ##1 tx_valid)
      else $error("reply not started");
   code_echo_a: assert property (
      $rose(tx_valid) |-> tx_data inside {8'h10, 8'h11, 8'h12, 8'h13,
      8'h19, 8'h1a, 8'h1b, 8'hff}) else $error("bad reply code");
   reopen_a: assert property (
      take && (pos == 3'h4 || (pos == 3'h0 && tx_data == 8'hff))
      |-> ##[1:2] rx_ready) else $error("rx not reopened");
endmodule
`default_nettype wire

/* tb/host_model.sv */
// Purpose: Remote host sending frames and collecting replies
// Assumes: Caller enters xfer just after a rising edge
// Notes:   slow stalls each reply byte after the first by one cycle
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // Clock
   input  wire logic       clock,
   // Command bytes to device
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   input  wire logic       rx_ready,
   // Reply bytes from device
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready
);
   logic slow;

   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b0;
      slow     = 1'b0;
   end

   task automatic xfer(input logic [7:0] c, input logic [31:0] a, b,
                       input int n, output logic [39:0] r);
      logic [71:0] f;
      f = {b, a, c};
      r = '0;
      // Whole frame back to back
      for (int i = 0; i < 9; i++) begin
         rx_valid <= 1'b1;
         rx_data  <= f[8*i +: 8];
         #1;
         while (rx_ready !== 1'b1) begin
            @(posedge clock);
            #1;
         end
         @(posedge clock);
      end
      rx_valid <= 1'b0;
      rx_data  <= ~f[71:64];
      // Next frame only after the whole reply
      for (int i = 0; i < n; i++) begin
         tx_ready <= !slow;
         #1;
         while ((tx_valid && tx_ready) !== 1'b1) begin
            @(posedge clock);
            tx_ready <= 1'b1;
            #1;
         end
         @(posedge clock);
         r[8*i +: 8] = tx_data;
      end
      tx_ready <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the pin command interpreter
// Assumes: Tasks are entered just after a rising edge
// Notes:   Expected values worked out by hand per scenario
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clock, nrst, boot_valid, rx_valid, rx_ready, tx_valid;
   logic        tx_ready, hsel, hwrite, hreadyout, hresp;
   logic [10:0] boot_func, boot_dir, boot_alow, pin_in, pin_out, pin_oe;
   logic [7:0]  rx_data, tx_data;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [39:0] rr;
   logic [7:0]  bad [5] = '{8'h00, 8'h14, 8'h18, 8'h1c, 8'hff};
   int          miscompares, cmp_count;

   gpio_command_interpreter DUT (.clock, .nrst, .boot_valid, .boot_func,
      .boot_dir, .boot_alow, .rx_valid, .rx_data, .rx_ready, .tx_valid,
      .tx_data, .tx_ready, .pin_in, .pin_out, .pin_oe, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
      .hrdata, .hresp);
   host_model host (.clock, .rx_valid, .rx_data, .rx_ready, .tx_valid,
      .tx_data, .tx_ready);

   always #2 clock = ~clock;

   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic boot(input logic v, input logic [10:0] f, d, a);
      nrst       <= 1'b0;
      boot_valid <= v;
      boot_func  <= f;
      boot_dir   <= d;
      boot_alow  <= a;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic cmd(input logic [7:0] c, input logic [31:0] a, b, e);
      logic ok;
      ok = c inside {8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1a, 8'h1b};
      host.xfer(c, a, b, ok ? 5 : 1, rr);
      chk({24'h0, rr[7:0]}, ok ? {24'h0, c} : 32'h0000_00ff);
      if (ok)
         chk(rr[39:8], e);
   endtask

   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      {boot_valid, boot_func, boot_dir, boot_alow} = '0;
      pin_in = 11'h7ff;
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      miscompares = 0;
      cmp_count = 0;
      boot(1'b0, 11'h000, 11'h000, 11'h000);
      chk(pin_oe, 32'h0);
      chk(pin_out, 32'h7ff);
      cmd(8'h10, 32'h0, 32'h0, 32'h7ff);
      cmd(8'h11, 32'hffff_ffff, 32'hffff_ffff, 32'h0);
      cmd(8'h12, 32'h0, 32'h0, 32'h7ff);
      host.slow = 1'b1;
      cmd(8'h19, 32'h3, 32'hffff_ffff, 32'h3);
      cmd(8'h1b, 32'h1, 32'h1, 32'h1);
      chk(pin_oe, 32'h3);
      chk(pin_out, 32'h7fe);
      cmd(8'h1a, 32'h2, 32'h0, 32'h7fd);
      chk(pin_out, 32'h7fc);
      host.slow = 1'b0;
      pin_in <= 11'h7fb;
      repeat (4) @(posedge clock);
      cmd(8'h13, 32'h0, 32'h0, 32'h5);
      ahb(1'b0, 32'h14, 32'h0, rd);
      chk(rd, 32'h5);
      ahb(1'b0, 32'h0c, 32'h0, rd);
      chk(rd, 32'h3);
      ahb(1'b0, 32'h10, 32'h0, rd);
      chk(rd, 32'h7fd);
      foreach (bad[i])
         cmd(bad[i], 32'h0, 32'h0, 32'h0);
      ahb(1'b0, 32'h18, 32'h0, rd);
      chk(rd, 32'h0005_0007);
      ahb(1'b1, 32'h100, 32'h1, rd);
      ahb(1'b0, 32'h00, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b1, 32'h08, 32'h0, rd);
      ahb(1'b0, 32'h08, 32'h0, rd);
      chk(rd, 32'h7ff);
      ahb(1'b0, 32'h40, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b1, 32'h00, 32'h1, rd);
      ahb(1'b0, 32'h00, 32'h0, rd);
      chk(rd, 32'h1);
      host.xfer(8'h10, 32'h0, 32'h0, 0, rr);
      repeat (20) @(posedge clock);
      chk({31'h0, tx_valid}, 32'h0);
      ahb(1'b0, 32'h04, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b1, 32'h00, 32'h0, rd);
      cmd(8'h10, 32'h0, 32'h0, 32'h7ff);
      boot(1'b1, 11'h203, 11'h001, 11'h7ff);
      cmd(8'h10, 32'h0, 32'h0, 32'h203);
      cmd(8'h11, 32'h0, 32'h0, 32'h1);
      cmd(8'h19, 32'hffff_ffff, 32'hffff_ffff, 32'h203);
      chk(pin_oe, 32'h203);
      chk(pin_out, 32'h7ff);
      end_of_test;
   end

   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      end_of_test;
   end
endmodule

bind gpio_command_interpreter gpio_cmd_sva chk_i (.clock(clock),
   .nrst(nrst), .rx_ready(rx_ready), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_ready(tx_ready));
`default_nettype wire
